// *** efc_defs.svh ***
// Offsets, field positions and reset values of the flash cipher block.
// Included by the package and by the design module.
`ifndef EFC_DEFS_SVH
`define EFC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EFC_OFS_BUF0 12'h000
`define EFC_OFS_BUF7 12'h01C
`define EFC_OFS_START 12'h020
`define EFC_OFS_ADDR 12'h024
`define EFC_OFS_DONE 12'h028
`define EFC_OFS_CFG 12'h02C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EFC_START_BIT 0
`define EFC_DONE_BIT 0
`define EFC_CFG_ENC_BIT 0
`define EFC_CFG_DEC_BIT 1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define EFC_CFG_RESET 2'h0
`define EFC_ADDR_RESET 32'h0000_0000
`define EFC_SEG_WORDS 8
`define EFC_TOGGLE_BITS 7

`endif

// *** efc_pkg.sv ***
// Types shared by the flash cipher block and its surroundings.
// Assumes efc_defs.svh is on the include path.
package efc_pkg;
  `include "efc_defs.svh"

  // ----------------------------------------------------------------
  // Fuse parameters
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] coding_scheme;
    logic [255:0] key_fuse_block;
    logic [3:0] key_tweak_select;
    logic dl_inhibit_encrypt;
    logic dl_inhibit_decrypt;
    logic [`EFC_TOGGLE_BITS-1:0] decrypt_toggle_count;
  } efc_fuse_t;

  // Cache read word returning from flash
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic [31:0] data;
  } efc_rd_t;

  // Flash write word from the write controller
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic [31:0] data;
  } efc_wr_t;

  typedef enum logic {EFC_BOOT_FLASH, EFC_BOOT_DOWNLOAD} efc_boot_t;

  typedef enum {ENC_IDLE, ENC_RUN} efc_enc_state_t;
endpackage : efc_pkg

// *** efc_cipher.sv ***
// Flash cipher path: key generator, encryption unit with AHB-Lite
// registers, and on-the-fly decryption of cache reads.
// Assumes fuse, boot and flash ports are on the clk domain.
//
// Notes on behaviour
// - Base key is formed from coding scheme and key fuse block.
// - Encrypt and decrypt keys come from base key, tweak select, address.
// - With tweak select all zero, keys ignore the flash address.
// - With nonzero tweak select, each eight-word block gets distinct keys.
// - One key generator feeds both units; they run concurrently.
// - Eight write-only buffers hold plaintext, word zero least significant.
// - Go bit encrypts the buffered words, then raises complete flag.
// - Encryption uses the key of the latched address, eight words out.
// - Operational and encrypted: write controller sends ciphertext instead.
// - Otherwise the write controller sends software data unchanged.
// - Flash boot: encryption operational exactly when encrypt enable set.
// - Download boot: needs encrypt enable and encrypt inhibit fuse clear.
// - No software read path to ciphertext or encrypt key.
// - Operational decryption decrypts cache reads with no software action.
// - Decrypt key hidden; decryption unit has no registers of its own.
// - Not operating: cache reads return raw flash contents.
// - Flash boot: decryption on when low seven toggle bits have odd ones.
// - Download boot: needs decrypt enable and decrypt inhibit fuse clear.
// - Six fuse parameters come in from the fuse controller.
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "efc_defs.svh"

module efc_cipher #(
  parameter int SEG_WORDS = `EFC_SEG_WORDS
) (
  input wire logic clk, // 20 MHz clock
  input wire logic reset_n, // Asynchronous reset
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response
  input wire efc_pkg::efc_fuse_t fuse, // Fuse parameters
  input wire efc_pkg::efc_boot_t boot_mode, // Boot mode
  input wire efc_pkg::efc_rd_t cache_rd_in, // Raw flash read word
  output efc_pkg::efc_rd_t cache_rd_out, // Word to the cache
  input wire efc_pkg::efc_wr_t flash_wr_in, // Write word from software
  output efc_pkg::efc_wr_t flash_wr_out, // Word to the flash
  output logic encrypt_operational, // Encryption unit active
  output logic decrypt_operational // Decryption unit active
);
  import efc_pkg::*;

  // ----------------------------------------------------------------
  // Key functions
  // ----------------------------------------------------------------
  // base key
  function automatic logic [255:0] base_key(input logic [1:0] scheme,
                                             input logic [255:0] blk);
    logic [255:0] k;
    k = blk;
    if (scheme != 2'h0) begin
      k = {blk[127:0], blk[127:0]} ^ {128'h0, blk[255:128]};
    end
    return k;
  endfunction : base_key

  function automatic logic [255:0] derive_key(input logic [255:0] kb,
                                               input logic [3:0] tweak,
                                               input logic [23:0] addr);
    logic [255:0] k;
    k = kb;
    if (tweak != 4'h0) begin
      // Every key word carries the block, so every keystream word differs
      for (int j = 0; j < 8; j++) begin
        k[j*32 +: 23] = kb[j*32 +: 23] ^ {tweak, addr[23:5]};
      end
      k[255:252] = kb[255:252] ^ tweak;
    end
    return k;
  endfunction : derive_key

  // Keystream word for one position; xor makes it its own inverse
  function automatic logic [31:0] key_word(input logic [255:0] k,
                                            input logic [2:0] idx);
    logic [31:0] a;
    logic [31:0] b;
    a = k[idx*32 +: 32];
    b = k[(3'(idx + 3'h3))*32 +: 32];
    return a ^ {b[26:0], b[31:27]} ^ {29'h0, idx};
  endfunction : key_word

  // Read mux; write-only and unmapped places answer zero
  function automatic logic [31:0] read_word(input logic [11:0] o,
                                             input logic done,
                                             input logic [1:0] cfg);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (o == `EFC_OFS_DONE) begin
      w = {31'h0, done};
    end else if (o == `EFC_OFS_CFG) begin
      w = {30'h0, cfg};
    end
    return w;
  endfunction : read_word

  // Aligned offset inside the plaintext buffers
  function automatic logic is_buf_ofs(input logic [11:0] o);
    return (o <= `EFC_OFS_BUF7) && (o[1:0] == 2'h0);
  endfunction : is_buf_ofs

  // ----------------------------------------------------------------
  // Register and state declarations
  // ----------------------------------------------------------------
  logic [31:0] buf_reg [SEG_WORDS];
  logic [31:0] buf_next [SEG_WORDS];
  logic [31:0] ct_reg [SEG_WORDS];
  logic [31:0] ct_next [SEG_WORDS];
  logic [23:0] addr_reg, addr_next;
  logic [1:0] cfg_reg, cfg_next;
  logic done_reg, done_next;
  logic seg_valid_reg, seg_valid_next;
  logic [2:0] cnt_reg, cnt_next;
  efc_enc_state_t state_reg, state_next;
  logic wr_pend_reg, wr_pend_next;
  logic [11:0] wr_ofs_reg, wr_ofs_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic hreadyout_reg, hreadyout_next;
  logic hresp_reg, hresp_next;
  efc_rd_t rd_reg, rd_next;
  efc_wr_t wr_reg, wr_next;
  logic enc_op_reg, enc_op_next;
  logic dec_op_reg, dec_op_next;
  logic [255:0] key_base;
  logic [255:0] key_enc;
  logic [255:0] key_dec;
  logic addr_phase;
  logic [11:0] ofs;
  logic start_wr;

  // ----------------------------------------------------------------
  // Key generator
  // ----------------------------------------------------------------
  // fuse inputs
  always_comb begin
    key_base = base_key(fuse.coding_scheme, fuse.key_fuse_block);
    key_enc = derive_key(key_base, fuse.key_tweak_select, addr_reg);
    key_dec = derive_key(key_base, fuse.key_tweak_select, cache_rd_in.addr);
  end

  // ----------------------------------------------------------------
  // Operating conditions
  // ----------------------------------------------------------------
  always_comb begin
    if (boot_mode == EFC_BOOT_FLASH) begin
      enc_op_next = cfg_reg[`EFC_CFG_ENC_BIT];
    end else begin
      enc_op_next = cfg_reg[`EFC_CFG_ENC_BIT] & ~fuse.dl_inhibit_encrypt;
    end
    if (boot_mode == EFC_BOOT_FLASH) begin
      dec_op_next = ^fuse.decrypt_toggle_count;
    end else begin
      dec_op_next = cfg_reg[`EFC_CFG_DEC_BIT] & ~fuse.dl_inhibit_decrypt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enc_op_reg <= 1'b0;
      dec_op_reg <= 1'b0;
    end else begin
      enc_op_reg <= enc_op_next;
      dec_op_reg <= dec_op_next;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign addr_phase = hsel & htrans[1] & hready;
  assign ofs = haddr[11:0];
  assign start_wr = wr_pend_reg & (wr_ofs_reg == `EFC_OFS_START) &
                    hwdata[`EFC_START_BIT];

  always_comb begin
    wr_pend_next = addr_phase & hwrite;
    wr_ofs_next = addr_phase ? ofs : wr_ofs_reg;
    hrdata_next = 32'h0000_0000;
    // only status and config read back
    if (addr_phase && !hwrite) begin
      hrdata_next = read_word(ofs, done_reg, cfg_reg);
    end
    // Zero wait states, always OKAY
    hreadyout_next = 1'b1;
    hresp_next = 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 12'h000;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_ofs_reg <= wr_ofs_next;
      hrdata_reg <= hrdata_next;
      hreadyout_reg <= hreadyout_next;
      hresp_reg <= hresp_next;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < SEG_WORDS; i++) begin
      buf_next[i] = buf_reg[i];
    end
    addr_next = addr_reg;
    cfg_next = cfg_reg;
    if (wr_pend_reg) begin
      if (is_buf_ofs(wr_ofs_reg)) begin
        buf_next[wr_ofs_reg[4:2]] = hwdata;
      end
      if (wr_ofs_reg == `EFC_OFS_ADDR) begin
        addr_next = hwdata[23:0];
      end
      if (wr_ofs_reg == `EFC_OFS_CFG) begin
        cfg_next = hwdata[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg <= 24'h00_0000;
      cfg_reg <= `EFC_CFG_RESET;
      for (int i = 0; i < SEG_WORDS; i++) begin
        buf_reg[i] <= 32'h0000_0000;
      end
    end else begin
      addr_reg <= addr_next;
      cfg_reg <= cfg_next;
      for (int i = 0; i < SEG_WORDS; i++) begin
        buf_reg[i] <= buf_next[i];
      end
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

  // ----------------------------------------------------------------
  // Encryption unit
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done_next = done_reg;
    seg_valid_next = seg_valid_reg;
    for (int i = 0; i < SEG_WORDS; i++) begin
      ct_next[i] = ct_reg[i];
    end
    case (state_reg)
      ENC_IDLE: begin
        if (start_wr && enc_op_reg) begin
          state_next = ENC_RUN;
          cnt_next = 3'h0;
          done_next = 1'b0;
          seg_valid_next = 1'b0;
        end
      end
      ENC_RUN: begin
        ct_next[cnt_reg] = buf_reg[cnt_reg] ^ key_word(key_enc, cnt_reg);
        cnt_next = 3'(cnt_reg + 3'h1);
        if (cnt_reg == 3'(SEG_WORDS - 1)) begin
          state_next = ENC_IDLE;
          done_next = 1'b1;
          seg_valid_next = 1'b1;
        end
      end
      default: begin
        state_next = ENC_IDLE;
      end
    endcase
    if (!enc_op_reg) begin
      seg_valid_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ENC_IDLE;
      cnt_reg <= 3'h0;
      done_reg <= 1'b0;
      seg_valid_reg <= 1'b0;
      for (int i = 0; i < SEG_WORDS; i++) begin
        ct_reg[i] <= 32'h0000_0000;
      end
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      seg_valid_reg <= seg_valid_next;
      for (int i = 0; i < SEG_WORDS; i++) begin
        ct_reg[i] <= ct_next[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Flash write path
  // ----------------------------------------------------------------
  always_comb begin
    wr_next = flash_wr_in;
    if (flash_wr_in.valid && enc_op_reg && seg_valid_reg) begin
      wr_next.data = ct_reg[flash_wr_in.addr[4:2]];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_reg <= '0;
    end else begin
      wr_reg <= wr_next;
    end
  end

  // ----------------------------------------------------------------
  // Cache read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_next = cache_rd_in;
    if (cache_rd_in.valid && dec_op_reg) begin
      rd_next.data = cache_rd_in.data ^ key_word(key_dec, cache_rd_in.addr[4:2]);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign flash_wr_out = wr_reg;
  assign cache_rd_out = rd_reg;
  assign encrypt_operational = enc_op_reg;
  assign decrypt_operational = dec_op_reg;
endmodule : efc_cipher

// *** efc_cipher_sva.sv ***
// Port checker for the flash cipher block.
// Bound to every efc_cipher instance; one clock, async low reset.
`timescale 1ns/1ps
module efc_cipher_chk (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire efc_pkg::efc_fuse_t fuse, // Fuses
  input wire efc_pkg::efc_boot_t boot_mode, // Boot mode
  input wire efc_pkg::efc_rd_t cache_rd_in, // Raw read
  input wire efc_pkg::efc_rd_t cache_rd_out, // Cache read
  input wire efc_pkg::efc_wr_t flash_wr_in, // Software write
  input wire efc_pkg::efc_wr_t flash_wr_out, // Flash write
  input wire logic encrypt_operational, // Encrypt on
  input wire logic decrypt_operational // Decrypt on
);
  import efc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_wo_read_zero: assert property (
    hsel && htrans[1] && hready && !hwrite && haddr[11:0] < 12'h028 |=> hrdata == 32'h0000_0000)
    else $error("write-only place read nonzero");
  a_rd_follows: assert property (
    cache_rd_in.valid |=> cache_rd_out.valid && cache_rd_out.addr == $past(cache_rd_in.addr))
    else $error("cache word lost or moved");
  a_rd_quiet: assert property (!cache_rd_in.valid |=> !cache_rd_out.valid)
    else $error("cache word out of nothing");
  a_rd_raw: assert property (
    cache_rd_in.valid && !decrypt_operational |=> cache_rd_out.data == $past(cache_rd_in.data))
    else $error("raw read altered");
  a_wr_follows: assert property (
    flash_wr_in.valid |=> flash_wr_out.valid && flash_wr_out.addr == $past(flash_wr_in.addr))
    else $error("flash write lost or moved");
  a_wr_plain: assert property (
    flash_wr_in.valid && !encrypt_operational |=> flash_wr_out.data == $past(flash_wr_in.data))
    else $error("plain write altered");
  a_dec_parity: assert property (
    boot_mode == EFC_BOOT_FLASH |=> decrypt_operational == ^$past(fuse.decrypt_toggle_count))
    else $error("decrypt state not toggle parity");
  a_dec_inhibit: assert property (
    boot_mode == EFC_BOOT_DOWNLOAD && fuse.dl_inhibit_decrypt |=> !decrypt_operational)
    else $error("decrypt on while inhibited");
  a_enc_inhibit: assert property (
    boot_mode == EFC_BOOT_DOWNLOAD && fuse.dl_inhibit_encrypt |=> !encrypt_operational)
    else $error("encrypt on while inhibited");
  c_enc_write: cover property (encrypt_operational && flash_wr_in.valid);
  c_dec_read: cover property (decrypt_operational && cache_rd_in.valid);
  c_plain_write: cover property (!encrypt_operational && flash_wr_in.valid);
endmodule : efc_cipher_chk

bind efc_cipher efc_cipher_chk i_chk (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .fuse, .boot_mode, .cache_rd_in, .cache_rd_out, .flash_wr_in,
  .flash_wr_out, .encrypt_operational, .decrypt_operational);

// *** efc_flash_model.sv ***
// External flash array behind the write controller and cache.
// Stores flash writes, replays reads one cycle after a request.
`timescale 1ns/1ps
module efc_flash_model (
  input wire logic clk, // Clock
  input wire efc_pkg::efc_wr_t wr, // Word to store
  input wire logic rd_req, // Read request
  input wire logic [23:0] rd_addr, // Read address
  output efc_pkg::efc_rd_t rd // Raw word out
);
  import efc_pkg::*;
  logic [31:0] mem [0:63];
  initial rd = '0;
  always @(posedge clk) begin
    if (wr.valid) mem[wr.addr[7:2]] <= wr.data;
    rd.valid <= rd_req;
    rd.addr <= rd_addr;
    rd.data <= rd_req ? mem[rd_addr[7:2]] : ~rd.data;
  end
endmodule : efc_flash_model

// *** tb.sv ***
// Self-checking bench for the flash cipher block.
// Drives AHB-Lite as the only master; flash model on the far side.
`timescale 1ns/1ps
module tb;
  import efc_pkg::*;
  logic clk = 0, reset_n = 0, hsel = 0, hwrite = 0, hready, rd_req = 0;
  logic hreadyout, hresp, enc_op, dec_op;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rv;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [23:0] rd_addr = '0;
  logic [31:0] pt [8];
  efc_fuse_t fuse = '0;
  efc_boot_t boot_mode = EFC_BOOT_FLASH;
  efc_rd_t rd_in, rd_out;
  efc_wr_t wr_in = '0, wr_out;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  assign hready = hreadyout;
  always #25 clk = ~clk;
  efc_cipher i_dut (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .fuse, .boot_mode, .cache_rd_in(rd_in), .cache_rd_out(rd_out),
    .flash_wr_in(wr_in), .flash_wr_out(wr_out), .encrypt_operational(enc_op),
    .decrypt_operational(dec_op));
  efc_flash_model i_flash (.clk, .wr(wr_out), .rd_req, .rd_addr, .rd(rd_in));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0_0000, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rv);
  endtask : wreg

  task automatic cread(input logic [23:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_req <= 1'b0;
    for (int k = 0; k < 4 && rd_out.valid !== 1'b1; k++) @(negedge clk);
    d = rd_out.data;
  endtask : cread

  task automatic fwrite8(input logic [23:0] a, input logic [31:0] base);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      wr_in <= {1'b1, a + 24'(4 * i), base + 32'(i)};
    end
    @(posedge clk);
    wr_in.valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : fwrite8

  task automatic seg(input logic [23:0] a);
    logic [31:0] d;
    wreg(12'h024, {8'h00, a});
    for (int i = 0; i < 8; i++) wreg(12'(4 * i), pt[i]);
    wreg(12'h020, 32'h0000_0001);
    ahb(1'b0, 12'h028, '0, d);
    chk("done after start", 0, d);
    for (int k = 0; k < 20 && d !== 32'h0000_0001; k++) ahb(1'b0, 12'h028, '0, d);
    chk("done flag", 1, d);
    fwrite8(a, 32'hD0D0_0000);
    for (int i = 0; i < 8; i++) begin
      cread(a + 24'(4 * i), d);
      chk("decrypted word", pt[i], d);
    end
  endtask : seg

  task automatic t_modes();
    logic e, d;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      boot_mode <= efc_boot_t'(i[0]);
      fuse.dl_inhibit_encrypt <= i[3];
      fuse.dl_inhibit_decrypt <= i[3];
      fuse.decrypt_toggle_count <= i[3] ? 7'h07 : 7'h03;
      wreg(12'h02C, {30'h0, i[2], i[1]});
      repeat (2) @(posedge clk);
      e = i[1] & (!i[0] | !i[3]);
      d = i[0] ? i[2] & !i[3] : i[3];
      chk("encrypt operational", e, enc_op);
      chk("decrypt operational", d, dec_op);
      ahb(1'b0, 12'h02C, '0, rv);
      chk("config readback", {30'h0, i[2], i[1]}, rv);
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_tweak(input logic [3:0] tw, input logic same);
    @(posedge clk);
    boot_mode <= EFC_BOOT_FLASH;
    fuse.decrypt_toggle_count <= 7'h01;
    fuse.key_tweak_select <= tw;
    wreg(12'h02C, 32'h0000_0003);
    seg(24'h00_0000);
    seg(24'h00_0020);
    for (int i = 0; i < 8; i++) chk("key by block", same, i_flash.mem[i] === i_flash.mem[i + 8]);
    $display("test tweak %h done", tw);
  endtask : t_tweak

  task automatic t_plain();
    @(posedge clk);
    fuse.decrypt_toggle_count <= 7'h03;
    wreg(12'h02C, 32'h0000_0000);
    fwrite8(24'h00_0040, 32'hD0D0_0000);
    for (int i = 0; i < 8; i++) begin
      cread(24'h00_0040 + 24'(4 * i), rv);
      chk("raw word", 32'hD0D0_0000 + 32'(i), rv);
    end
    cread(24'h00_0000, rv);
    chk("raw cipher word", i_flash.mem[0], rv);
    $display("test plain done");
  endtask : t_plain

  task automatic t_map();
    wreg(12'h030, 32'hFFFF_FFFF);
    ahb(1'b0, 12'h030, '0, rv);
    chk("unmapped read", 0, rv);
    ahb(1'b0, 12'h000, '0, rv);
    chk("buffer read", 0, rv);
    ahb(1'b0, 12'h024, '0, rv);
    chk("address read", 0, rv);
    ahb(1'b0, 12'h02C, '0, rv);
    chk("config kept", 0, rv);
    $display("test map done");
  endtask : t_map

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    for (int i = 0; i < 8; i++) pt[i] = 32'hC0DE_0000 | 32'(i * 17);
    fuse.key_fuse_block = {8{32'h1357_9BDF}};
    fuse.decrypt_toggle_count = 7'h01;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_modes();
    t_tweak(4'h0, 1'b1);
    t_tweak(4'hF, 1'b0);
    t_plain();
    t_map();
    conclude();
  end
endmodule : tb
